// [pkg/light_pkg.sv]
// Constants and carriers shared by the light conversion control block.
// Assumes a single 10 MHz system clock; all times are derived from it.
package light_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_PERIOD_NS  = 100;
    localparam int TICK_NS        = 1_000_000;
    // One millisecond tick, rounded up to whole clock cycles.
    localparam int TICK_CYCLES    = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_CONV_MS  = 100;
    localparam int LONG_CONV_MS   = 800;
    localparam int MS_CNT_W       = 10;
    localparam int DIV_CNT_W      = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions of the conversion control word.
    localparam int SCALE_MSB      = 15;
    localparam int SCALE_LSB      = 12;
    localparam int INTEG_BIT      = 11;
    localparam int MODE_MSB       = 10;
    localparam int MODE_LSB       = 9;
    localparam int OVERLOAD_BIT   = 8;
    localparam int DONE_BIT       = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Codes and reset values.
    localparam logic [3:0]  SCALE_AUTO     = 4'hC;
    localparam logic [3:0]  SCALE_MAX      = 4'hB;
    localparam logic [3:0]  SCALE_MIN      = 4'h0;
    localparam logic [1:0]  MODE_SHUTDOWN  = 2'h0;
    localparam logic [1:0]  MODE_SINGLE    = 2'h1;
    localparam logic [15:0] CTRL_RESET     = 16'hC810;
    localparam logic [4:0]  AUX_RESET      = 5'h10;
    localparam logic [11:0] MANT_FULL      = 12'hFFF;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic [3:0] scale_code;
        logic       integration_length;
        logic [1:0] mode;
        logic       overload_flag;
        logic       done_flag;
        logic       above_limit_flag;
        logic       below_limit_flag;
        logic [4:0] aux_fields;
    } ctrl_word_t;

    typedef struct packed {
        logic [3:0]  exponent;
        logic [11:0] mantissa;
    } result_word_t;

endpackage

// [core/conversion_timer.sv]
// Conversion length timer: a millisecond enable divider and a millisecond counter.
// Assumes restart_i and run_i come from flip-flops of the control block.
`timescale 1ns/100ps
module conversion_timer #(
    parameter int TICK_CYCLES = light_pkg::TICK_CYCLES
) (
    input  wire logic clk_sys_i,
    input  wire logic arst_n_i,
    input  wire logic run_i,
    input  wire logic restart_i,
    input  wire logic long_i,
    output logic      expire_o
);

    typedef struct packed {
        logic [light_pkg::DIV_CNT_W-1:0] div_cnt;
        logic [light_pkg::MS_CNT_W-1:0]  ms_cnt;
        logic                            expire;
    } timer_state_t;

    localparam logic [light_pkg::DIV_CNT_W-1:0] DIV_LAST =
        light_pkg::DIV_CNT_W'(TICK_CYCLES - 1);
    localparam logic [light_pkg::MS_CNT_W-1:0] SHORT_LAST =
        light_pkg::MS_CNT_W'(light_pkg::SHORT_CONV_MS - 1);
    localparam logic [light_pkg::MS_CNT_W-1:0] LONG_LAST =
        light_pkg::MS_CNT_W'(light_pkg::LONG_CONV_MS - 1);

    timer_state_t st_reg;
    timer_state_t st_next;

    always_comb begin
        st_next        = st_reg;
        st_next.expire = 1'b0;
        if (!run_i || restart_i) begin
            st_next.div_cnt = '0;
            st_next.ms_cnt  = '0;
        end else if (st_reg.div_cnt == DIV_LAST) begin
            st_next.div_cnt = '0;
            if (st_reg.ms_cnt == (long_i ? LONG_LAST : SHORT_LAST)) begin
                st_next.ms_cnt = '0;
                st_next.expire = 1'b1;
            end else begin
                st_next.ms_cnt = st_reg.ms_cnt + 1'b1;
            end
        end else begin
            st_next.div_cnt = st_reg.div_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign expire_o = st_reg.expire;

endmodule

// [core/light_conversion_control.sv]
// Conversion control of an ambient-light sensor: control word, mode sequencing,
// automatic range escalation, overload flag and result word.
// Assumes a serial front end delivers whole 16-bit accesses as strobes, and an
// analog converter reports overload as a level and its mantissa at the end.
// What this block does
// - Four-bit read/write scale code in bits 15:12, reset to automatic code 1100b.
// - Scale code 1100b picks range automatically, reported in the result exponent.
// - Bit 11 selects conversion length: zero 100 ms, one 800 ms; resets one.
// - Short length drops resolution: one bit range 5, two bits 1-4, three range 0.
// - Result layout and LSB weight never change with conversion length.
// - Mode bits 10:9 reset 00b: shutdown, 01b single-shot, 1xb continuous.
// - Single-shot reads 01b while running, then returns itself to 00b.
// - Entering shutdown leaves done and limit flags untouched.
// - Read-only overload bit 8 is re-evaluated at the end of every conversion.
// - Manual range may flag overload after a transient even if result fits.
// - Automatic range flags overload only beyond the maximum range's full scale.
// - Automatic overload below maximum aborts, steps range up, restarts; flag at end.
// - A control word write aborts a running conversion; restarts if mode asks.
// - Done bit sets at conversion end; clears on read or non-shutdown write.
// - Result holds 4-bit exponent above 12-bit straight-binary mantissa.
`timescale 1ns/100ps
module light_conversion_control #(
    parameter int TICK_CYCLES = light_pkg::TICK_CYCLES
) (
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    input  wire logic        wr_en_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic        rd_en_i,
    input  wire logic        above_limit_flag_i,
    input  wire logic        below_limit_flag_i,
    input  wire logic        adc_overload_i,
    input  wire logic [11:0] adc_mantissa_i,
    output logic [15:0]      rd_data_o,
    output logic [15:0]      result_o,
    output logic             done_pulse_o,
    output logic             adc_run_o,
    output logic             adc_restart_o,
    output logic [3:0]       adc_range_o,
    output logic [4:0]       aux_fields_o
);

    typedef enum logic { ST_IDLE, ST_RUN } conv_state_t;

    typedef struct packed {
        conv_state_t               state;
        light_pkg::ctrl_word_t     ctrl;
        light_pkg::result_word_t   result;
        logic [3:0]                cur_range;
        logic                      ovl_seen;
        logic                      restart;
        logic                      done_pulse;
        logic [15:0]               rd_word;
    } ctrl_state_t;

    ctrl_state_t st_reg;
    ctrl_state_t st_next;
    logic        expire;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [11:0] resolution_mask(input logic [3:0] range,
                                                    input logic       long_len);
        logic [11:0] mask;
        mask = light_pkg::MANT_FULL;
        if (!long_len) begin
            if (range == 4'h0) begin
                mask = 12'hFF8;
            end else if (range <= 4'h4) begin
                mask = 12'hFFC;
            end else if (range == 4'h5) begin
                mask = 12'hFFE;
            end
        end
        return mask;
    endfunction

    // The first range of a conversion: the lowest one when ranging automatically.
    function automatic logic [3:0] first_range(input logic [3:0] scale);
        return (scale == light_pkg::SCALE_AUTO) ? light_pkg::SCALE_MIN : scale;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Conversion length timer.

    conversion_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .run_i     (st_reg.state == ST_RUN),
        .restart_i (st_reg.restart),
        .long_i    (st_reg.ctrl.integration_length),
        .expire_o  (expire)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic auto_mode;
        logic clear_done;
        logic set_done;
        auto_mode  = 1'b0;
        clear_done = 1'b0;
        set_done   = 1'b0;

        st_next            = st_reg;
        st_next.restart    = 1'b0;
        st_next.done_pulse = 1'b0;
        st_next.ctrl.above_limit_flag = above_limit_flag_i;
        st_next.ctrl.below_limit_flag = below_limit_flag_i;

        if (rd_en_i) begin
            clear_done = 1'b1;
        end

        if (wr_en_i) begin
            st_next.ctrl.scale_code =
                wr_data_i[light_pkg::SCALE_MSB:light_pkg::SCALE_LSB];
            st_next.ctrl.integration_length = wr_data_i[light_pkg::INTEG_BIT];
            st_next.ctrl.mode = wr_data_i[light_pkg::MODE_MSB:light_pkg::MODE_LSB];
            st_next.ctrl.aux_fields = wr_data_i[4:0];
            if (wr_data_i[light_pkg::MODE_MSB:light_pkg::MODE_LSB] ==
                light_pkg::MODE_SHUTDOWN) begin
                st_next.state = ST_IDLE;
            end else begin
                clear_done        = 1'b1;
                st_next.state     = ST_RUN;
                st_next.restart   = 1'b1;
                st_next.ovl_seen  = 1'b0;
                st_next.cur_range = first_range(
                    wr_data_i[light_pkg::SCALE_MSB:light_pkg::SCALE_LSB]);
            end
        end else if (st_reg.state == ST_RUN && !st_reg.restart) begin
            auto_mode = (st_reg.ctrl.scale_code == light_pkg::SCALE_AUTO);
            if (adc_overload_i && auto_mode &&
                st_reg.cur_range < light_pkg::SCALE_MAX) begin
                st_next.cur_range = st_reg.cur_range + 1'b1;
                st_next.restart   = 1'b1;
            end else if (expire) begin
                st_next.ctrl.overload_flag = st_reg.ovl_seen || adc_overload_i;
                st_next.result.exponent = st_reg.cur_range;
                st_next.result.mantissa = adc_mantissa_i & resolution_mask(
                    st_reg.cur_range, st_reg.ctrl.integration_length);
                set_done           = 1'b1;
                st_next.done_pulse = 1'b1;
                st_next.ovl_seen   = 1'b0;
                if (st_reg.ctrl.mode == light_pkg::MODE_SINGLE) begin
                    st_next.ctrl.mode = light_pkg::MODE_SHUTDOWN;
                    st_next.state     = ST_IDLE;
                end else begin
                    st_next.restart   = 1'b1;
                    st_next.cur_range = first_range(st_reg.ctrl.scale_code);
                end
            end else if (adc_overload_i) begin
                st_next.ovl_seen = 1'b1;
            end
        end

        if (set_done) begin
            st_next.ctrl.done_flag = 1'b1;
        end else if (clear_done) begin
            st_next.ctrl.done_flag = 1'b0;
        end

        st_next.rd_word = st_next.ctrl;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg                         <= '0;
            st_reg.state                   <= ST_IDLE;
            st_reg.ctrl                    <= light_pkg::CTRL_RESET;
            st_reg.ctrl.aux_fields         <= light_pkg::AUX_RESET;
            st_reg.cur_range               <= light_pkg::SCALE_MIN;
            st_reg.rd_word                 <= light_pkg::CTRL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register.

    assign rd_data_o     = st_reg.rd_word;
    assign result_o      = st_reg.result;
    assign done_pulse_o  = st_reg.done_pulse;
    assign adc_run_o     = (st_reg.state == ST_RUN);
    assign adc_restart_o = st_reg.restart;
    assign adc_range_o   = st_reg.cur_range;
    assign aux_fields_o  = st_reg.ctrl.aux_fields;

endmodule

// [testbench/adc_model.sv]
// Behavioural converter on the far side of the conversion control block.
// Assumes the bench sets the lowest range that holds the light, and the level.
`timescale 1ns/100ps
module adc_model (
    input  wire logic        run_i,
    input  wire logic [3:0]  range_i,
    input  wire logic [3:0]  need_i,
    input  wire logic [11:0] level_i,
    output logic             overload_o,
    output logic [11:0]      mantissa_o
);
    // Overload persists while the range is below what the light needs.
    assign overload_o = run_i && (range_i < need_i);
    // Idle output is inverted so a sample taken outside a conversion shows up.
    assign mantissa_o = run_i ? level_i : ~level_i;
endmodule

// [testbench/light_monitor.sv]
// Concurrent checks on the ports of the conversion control block.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
module light_monitor #(
    parameter int TICK_CYCLES = light_pkg::TICK_CYCLES
) (
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    input  wire logic        wr_en_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic        rd_en_i,
    input  wire logic        adc_overload_i,
    input  wire logic [15:0] rd_data_o,
    input  wire logic [15:0] result_o,
    input  wire logic        done_pulse_o,
    input  wire logic        adc_run_o,
    input  wire logic        adc_restart_o,
    input  wire logic [3:0]  adc_range_o
);
    logic [31:0] cnt_reg;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) cnt_reg <= 32'h0;
        else if (adc_restart_o) cnt_reg <= 32'h1;
        else cnt_reg <= cnt_reg + 32'h1;
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_ovl;
        rd_data_o[15:12] == light_pkg::SCALE_AUTO && adc_run_o && !adc_restart_o
            && adc_overload_i && adc_range_o < light_pkg::SCALE_MAX && !wr_en_i;
    endsequence
    sequence s_step;
        adc_restart_o && adc_range_o == $past(adc_range_o) + 4'h1;
    endsequence
    property p_auto_step; s_ovl |=> s_step; endproperty
    a_auto_step: assert property (p_auto_step) else $error("range step missing");
    property p_latency;
        done_pulse_o |-> cnt_reg == 2 + (rd_data_o[11] ? 800 : 100) * TICK_CYCLES;
    endproperty
    a_latency: assert property (p_latency) else $error("conversion length wrong");
    property p_short_trunc;
        done_pulse_o && !rd_data_o[11] && result_o[15:12] == 4'h0 |-> result_o[2:0] == 3'h0;
    endproperty
    a_short_trunc: assert property (p_short_trunc) else $error("low bits kept");
    property p_write_fields;
        wr_en_i |=> rd_data_o[15:9] == $past(wr_data_i[15:9])
            && rd_data_o[4:0] == $past(wr_data_i[4:0]);
    endproperty
    a_write_fields: assert property (p_write_fields) else $error("write not stored");
    property p_write_restart;
        wr_en_i && wr_data_i[10:9] != light_pkg::MODE_SHUTDOWN
            |=> adc_restart_o && adc_run_o && !rd_data_o[7];
    endproperty
    a_write_restart: assert property (p_write_restart) else $error("no restart");
    property p_shutdown_write;
        wr_en_i && !rd_en_i && wr_data_i[10:9] == light_pkg::MODE_SHUTDOWN
            |=> !adc_run_o && rd_data_o[7] == $past(rd_data_o[7]);
    endproperty
    a_shutdown_write: assert property (p_shutdown_write) else $error("shutdown bad");
    property p_read_clear; rd_en_i && !wr_en_i |=> !rd_data_o[7] || done_pulse_o; endproperty
    a_read_clear: assert property (p_read_clear) else $error("done kept");
    property p_single_end;
        done_pulse_o && $past(rd_data_o[10:9]) == light_pkg::MODE_SINGLE
            |-> rd_data_o[10:9] == light_pkg::MODE_SHUTDOWN && !adc_run_o;
    endproperty
    a_single_end: assert property (p_single_end) else $error("single not ended");
    property p_range_manual;
        adc_run_o && rd_data_o[15:12] < light_pkg::SCALE_AUTO
            |-> adc_range_o == rd_data_o[15:12];
    endproperty
    a_range_manual: assert property (p_range_manual) else $error("range wrong");
    property p_result_manual;
        done_pulse_o && rd_data_o[15:12] < light_pkg::SCALE_AUTO
            |-> result_o[15:12] == rd_data_o[15:12];
    endproperty
    a_result_manual: assert property (p_result_manual) else $error("exponent bad");
    property p_result_auto;
        done_pulse_o && rd_data_o[15:12] == light_pkg::SCALE_AUTO
            |-> result_o[15:12] == $past(adc_range_o);
    endproperty
    a_result_auto: assert property (p_result_auto) else $error("auto exponent bad");
endmodule
bind light_conversion_control light_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i),
    .rd_en_i(rd_en_i), .adc_overload_i(adc_overload_i), .rd_data_o(rd_data_o),
    .result_o(result_o), .done_pulse_o(done_pulse_o), .adc_run_o(adc_run_o),
    .adc_restart_o(adc_restart_o), .adc_range_o(adc_range_o));

// [testbench/light_conversion_control_tb_top.sv]
// Self-checking bench for the conversion control block and its converter model.
// Assumes a one-cycle millisecond, so a conversion ends 103 or 803 cycles after its write, two more per automatic range step.
`timescale 1ns/100ps
module light_conversion_control_tb_top;
    localparam int TICK = 1;
    localparam logic [11:0] LVL = 12'hABF;
    logic clk_sys_i = 1'b0, arst_n_i = 1'b0, wr_en_i = 1'b0, rd_en_i = 1'b0;
    logic above_i = 1'b0, below_i = 1'b0, ovl, run, rst, dp;
    logic [15:0] wr_data_i = 16'h0000, rd_data_o, res, v;
    logic [11:0] mant;
    logic [3:0]  need = 4'h0, rng;
    logic [4:0]  aux;
    int          n_fail = 0, n_tests = 0, n;
    always #50 clk_sys_i = ~clk_sys_i;
    light_conversion_control #(.TICK_CYCLES(TICK)) uut (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i),
        .above_limit_flag_i(above_i), .below_limit_flag_i(below_i), .adc_overload_i(ovl),
        .adc_mantissa_i(mant), .rd_data_o(rd_data_o), .result_o(res), .done_pulse_o(dp),
        .adc_run_o(run), .adc_restart_o(rst), .adc_range_o(rng), .aux_fields_o(aux));
    adc_model u_adc (.run_i(run), .range_i(rng), .need_i(need), .level_i(LVL),
        .overload_o(ovl), .mantissa_o(mant));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // no reserved codes
    // Every written scale code stays within 0 to 1100b.
    task automatic wr(input logic [15:0] w);
        @(negedge clk_sys_i) begin wr_en_i = 1'b1; wr_data_i = w; end
        @(negedge clk_sys_i) wr_en_i = 1'b0;
    endtask
    task automatic wait_done(input int lim);
        n = 1;
        while (dp !== 1'b1 && n < lim) begin
            @(negedge clk_sys_i);
            n++;
        end
        check("done pulse", {15'h0, dp}, 16'h0001);
    endtask
    task automatic single(input logic [15:0] w, input logic [3:0] nd,
                          input logic [15:0] r, c, input int lat);
        need = nd;
        wr(w);
        wait_done(9000);
        if (lat > 0) check("latency", 16'(n), 16'(lat));
        check("result", res, r);
        check("ctrl", rd_data_o, c);
    endtask
    task automatic abort_shutdown();
        need = 4'h0;
        wr(16'h0410);
        repeat (50) @(negedge clk_sys_i);
        wr(16'h0410);
        wait_done(900);
        check("abort latency", 16'(n), 16'd103);
        check("done set", rd_data_o, 16'h0490);
        @(negedge clk_sys_i) begin rd_en_i = 1'b1; v = rd_data_o; end
        @(negedge clk_sys_i) rd_en_i = 1'b0;
        check("read data", v, 16'h0490);
        check("read clear", rd_data_o, 16'h0410);
        wait_done(200);
        wr(16'h0010);
        check("shutdown keeps", rd_data_o, 16'h0090);
        check("stopped", {15'h0, run}, 16'h0000);
        above_i = 1'b1;
        below_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        check("flag kept", rd_data_o, 16'h00F0);
        wr(16'h041A);
        check("write clear", rd_data_o, 16'h047A);
        check("aux out", {11'h0, aux}, 16'h001A);
        above_i = 1'b0;
        below_i = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        check("reset word", rd_data_o, 16'hC810);
        check("reset result", res, 16'h0000);
        single(16'h53F0, 4'h0, 16'h5ABE, 16'h5090, 103);
        single(16'h03F0, 4'h0, 16'h0AB8, 16'h0090, 103);
        single(16'h33F0, 4'h0, 16'h3ABC, 16'h3090, 103);
        single(16'h63F0, 4'h0, 16'h6ABF, 16'h6090, 103);
        single(16'h0BF0, 4'h0, 16'h0ABF, 16'h0890, 803);
        single(16'hCA10, 4'h0, 16'h0ABF, 16'hC890, 803);
        single(16'hCA10, 4'h3, 16'h3ABF, 16'hC890, 0);
        single(16'hCA10, 4'hF, 16'hBABF, 16'hC990, 0);
        single(16'h2210, 4'h5, 16'h2ABC, 16'h2190, 103);
        single(16'h2210, 4'h0, 16'h2ABC, 16'h2090, 103);
        abort_shutdown();
        summarize();
    end
    initial begin
        #1_500_000;
        n_fail++;
        summarize();
    end
endmodule
